// ### hw/lds_pkg.sv
// Package with types and timing constants for the latched dual bank memory controller.
package lds_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int BANK_ADDR_W = 12;

    // ****************************************
    // Timing in nanoseconds, clock period in picoseconds, and derived cycle counts
    // ****************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int T_LATCH_PULSE_NS = 8;
    localparam int T_ADDR_HOLD_NS = 5;
    localparam int T_ACCESS_NS = 20;
    localparam int T_WRITE_PULSE_NS = 15;
    localparam int T_OUT_OFF_NS = 10;
    localparam int SYNC_STAGES = 3;

    // Least times round up to whole cycles, never below one.
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int LATCH_CYC = min_cycles(T_LATCH_PULSE_NS);
    localparam int HOLD_CYC = min_cycles(T_ADDR_HOLD_NS);
    localparam int READ_CYC = min_cycles(T_ACCESS_NS) + SYNC_STAGES;
    localparam int WRITE_CYC = min_cycles(T_WRITE_PULSE_NS);
    localparam int OFF_CYC = min_cycles(T_OUT_OFF_NS);

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATCH = 3'b001,
        ST_HOLD = 3'b010,
        ST_READ = 3'b011,
        ST_WRITE = 3'b100,
        ST_RECOVER = 3'b101
    } lds_state_t;

    typedef struct packed {
        logic write;
        logic [1:0] bank_mask;
        logic [ADDR_W-1:0] addr;
        logic [1:0] byte_en;
        logic [DATA_W-1:0] wdata;
    } lds_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic latch_strobe;
        logic chip_enable_n;
        logic low_sel_n;
        logic high_sel_n;
        logic oe_a_n;
        logic oe_b_n;
        logic we_a_n;
        logic we_b_n;
        logic data_oe;
    } lds_pins_t;

    localparam lds_pins_t PINS_RESET = '{address: '0, latch_strobe: 1'b0,
        chip_enable_n: 1'b1, low_sel_n: 1'b1, high_sel_n: 1'b1, oe_a_n: 1'b1,
        oe_b_n: 1'b1, we_a_n: 1'b1, we_b_n: 1'b1, data_oe: 1'b0};
    localparam logic [3:0] CNT_ZERO = 4'h0;

endpackage

// ### hw/lds_host.sv
// Controller that drives the latched dual bank cache memory through its pins.
`timescale 1ns/100ps

module lds_host
    import lds_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int DATA_BITS = DATA_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Configuration strap level, high selects the two-bank arrangement.
    input wire logic cfg_dual_mode,
    // Request port.
    input wire logic req_valid,
    output logic req_ready,
    input wire lds_req_t req,
    // Read answer.
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    // Memory pins.
    output logic [ADDR_W-1:0] latched_address,
    output logic address_latch_strobe,
    output logic chip_enable_n,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic bank_a_output_enable_n,
    output logic bank_b_output_enable_n,
    output logic bank_a_write_enable_n,
    output logic bank_b_write_enable_n,
    // Two-way data pins.
    input wire logic [DATA_W-1:0] data_io_i,
    output logic [DATA_W-1:0] data_io_o,
    output logic data_io_oe
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W) begin : g_bad_width
        $error("Only a 13-bit address and a 16-bit data path are supported.");
    end

    // ****************************************
    // State
    // ****************************************
    lds_state_t state_q, state_d;
    lds_req_t req_q, req_d;
    lds_pins_t pins_q, pins_d;
    logic [3:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] sync1_q, sync2_q, sync3_q;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // Handshake and stage completion terms.
    wire accept = req_valid && (state_q == ST_IDLE);
    wire sync_agree = (sync2_q == sync3_q);
    wire latch_done = (cnt_q == 4'(LATCH_CYC - 1));
    wire hold_done = (cnt_q == 4'(HOLD_CYC - 1));
    wire read_done = (cnt_q >= 4'(READ_CYC - 1)) && sync_agree;
    wire write_done = (cnt_q == 4'(WRITE_CYC - 1));
    wire recover_done = (cnt_q == 4'(OFF_CYC - 1));

    // Next state of the access sequence.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (accept) state_d = ST_LATCH;
            ST_LATCH: if (latch_done) state_d = ST_HOLD;
            ST_HOLD: if (hold_done) state_d = req_q.write ? ST_WRITE : ST_READ;
            ST_READ: if (read_done) state_d = ST_RECOVER;
            ST_WRITE: if (write_done) state_d = ST_RECOVER;
            ST_RECOVER: if (recover_done) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Cycle counter restarts on every change of state.
    assign cnt_d = (state_d != state_q) ? CNT_ZERO : cnt_q + 4'h1;
    assign req_d = accept ? req : req_q;
    assign req_ready = (state_q == ST_IDLE);

    // ****************************************
    // Pin decode from the next state
    // ****************************************
    wire in_read = (state_d == ST_READ);
    wire in_write = (state_d == ST_WRITE);
    wire in_access = in_read || in_write;
    wire dual = cfg_dual_mode;
    // Dual mode picks one bank for reads, bank A when both are asked for.
    wire read_a = dual ? (req_d.bank_mask[0] || !req_d.bank_mask[1]) : 1'b1;
    // Single-array mode drives both enables of each pair as one, so both go low together.
    wire read_b = dual ? !read_a : 1'b1;
    wire write_a = dual ? req_d.bank_mask[0] : 1'b1;
    wire write_b = dual ? req_d.bank_mask[1] : 1'b1;
    // Top bit is driven low in dual mode and carried in direct mode.
    wire [ADDR_W-1:0] pin_addr = dual ? {1'b0, req_d.addr[BANK_ADDR_W-1:0]}
                                      : req_d.addr;
    // Byte selects, with at least the low byte when none was asked for.
    wire low_sel = req_d.byte_en[0] || !req_d.byte_en[1];

    // Next pin levels, registered so the pins change cleanly.
    always_comb begin
        pins_d = PINS_RESET;
        pins_d.address = (state_d == ST_IDLE) ? pins_q.address : pin_addr;
        pins_d.latch_strobe = (state_d == ST_LATCH);
        pins_d.chip_enable_n = !in_access;
        pins_d.low_sel_n = !(in_access && low_sel);
        pins_d.high_sel_n = !(in_access && req_d.byte_en[1]);
        pins_d.oe_a_n = !(in_read && read_a);
        pins_d.oe_b_n = !(in_read && read_b);
        pins_d.we_a_n = !(in_write && write_a);
        pins_d.we_b_n = !(in_write && write_b);
        // Data stays driven one cycle past the write for hold time.
        pins_d.data_oe = in_write || (state_d == ST_RECOVER && req_d.write);
    end

    // Read answer taken once the synchronised data has settled.
    assign rvalid_d = (state_q == ST_READ) && read_done;
    assign rdata_d = rvalid_d ? sync3_q : rdata_q;

    // State, request and pin registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
            req_q <= '0;
            pins_q <= PINS_RESET;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
            pins_q <= pins_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
        end
    end

    // Three-stage synchroniser on the returning data pins.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= data_io_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign latched_address = pins_q.address;
    assign address_latch_strobe = pins_q.latch_strobe;
    assign chip_enable_n = pins_q.chip_enable_n;
    assign low_byte_select_n = pins_q.low_sel_n;
    assign high_byte_select_n = pins_q.high_sel_n;
    assign bank_a_output_enable_n = pins_q.oe_a_n;
    assign bank_b_output_enable_n = pins_q.oe_b_n;
    assign bank_a_write_enable_n = pins_q.we_a_n;
    assign bank_b_write_enable_n = pins_q.we_b_n;
    assign data_io_o = req_q.wdata;
    assign data_io_oe = pins_q.data_oe;
    assign rsp_valid = rvalid_q;
    assign rsp_data = rdata_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire any_oe = !pins_q.oe_a_n || !pins_q.oe_b_n;
    wire any_we = !pins_q.we_a_n || !pins_q.we_b_n;

    a_read_no_write: assert property (any_oe |-> !any_we && !pins_q.data_oe)
        else $error("Write enable or data drive during a read.");
    a_dual_single_oe: assert property (cfg_dual_mode |-> !(!pins_q.oe_a_n && !pins_q.oe_b_n))
        else $error("Both output enables low in dual mode.");
    a_direct_oe_tied: assert property (!cfg_dual_mode |-> pins_q.oe_a_n == pins_q.oe_b_n)
        else $error("Output enables differ in single-array mode.");
    a_direct_we_tied: assert property (!cfg_dual_mode |-> pins_q.we_a_n == pins_q.we_b_n)
        else $error("Write enables differ in single-array mode.");
    a_latch_addr_stable: assert property ($fell(address_latch_strobe) |->
        latched_address == $past(latched_address) ##1 $stable(latched_address))
        else $error("Address moved around the latch edge.");
    a_access_needs_ce: assert property ((any_oe || any_we) |-> !chip_enable_n)
        else $error("Enable without global select.");
    a_byte_selected: assert property (!chip_enable_n |-> !(low_byte_select_n && high_byte_select_n))
        else $error("Access with no byte selected.");
    a_dual_msb_low: assert property (cfg_dual_mode && !chip_enable_n |-> !latched_address[ADDR_W-1])
        else $error("Top address bit set in dual mode.");
    a_latch_before_use: assert property ($fell(chip_enable_n) |->
        $past(address_latch_strobe, 2) && !address_latch_strobe)
        else $error("Access did not follow a latch pulse.");
    a_read_answer: assert property ($rose(rsp_valid) |-> $past(any_oe))
        else $error("Answer without an output enable.");

    c_read: cover property (req_valid && req_ready && !req.write ##[1:20] rsp_valid);
    c_write: cover property ($fell(bank_a_write_enable_n) ##[1:4] $rose(bank_a_write_enable_n));
    c_dual_both: cover property (cfg_dual_mode && !bank_a_write_enable_n && !bank_b_write_enable_n);

endmodule

// ### testbench/lds_mem_model.sv
// Pin level model of the latched dual bank cache memory.
`timescale 1ns/100ps

module lds_mem_model
    import lds_pkg::*;
(
    // Strap and answer speed.
    input wire logic dual,
    input wire logic slow,
    // Pins from the controller.
    input wire lds_pins_t pins,
    input wire logic [DATA_W-1:0] bus_in,
    // Data the memory puts on the pins.
    output logic [DATA_W-1:0] bus_out
);
    logic [DATA_W-1:0] mem [0:8191];
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] drv;
    logic [DATA_W-1:0] last_q;
    logic sel_on;
    logic rd_a;
    logic rd_b;
    logic rd_on;
    logic [ADDR_W-1:0] rd_idx;
    wire [DATA_W-1:0] #30 drv_slow = drv;

    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = '0;
        last_q = '0;
    end

    // All thirteen bits are captured when the strobe falls.
    always @(negedge pins.latch_strobe) addr_q = pins.address;

    // Decode of selects and bank enables.
    assign sel_on = !pins.chip_enable_n && !(pins.low_sel_n && pins.high_sel_n);
    assign rd_a = dual ? (!pins.oe_a_n && pins.oe_b_n) : (!pins.oe_a_n && !pins.oe_b_n);
    assign rd_b = dual && pins.oe_a_n && !pins.oe_b_n;
    assign rd_idx = dual ? {rd_b, addr_q[11:0]} : addr_q;
    assign rd_on = sel_on && (rd_a || rd_b) && pins.we_a_n && pins.we_b_n;
    assign bus_out = slow ? drv_slow : drv;

    task automatic put(input logic [ADDR_W-1:0] idx);
        if (!pins.low_sel_n) mem[idx][7:0] = bus_in[7:0];
        if (!pins.high_sel_n) mem[idx][15:8] = bus_in[15:8];
    endtask

    // Writes follow the pins while active, so a write ended by either strobe keeps the data.
    always @(pins or bus_in or addr_q or dual or rd_on or rd_idx) begin
        if (sel_on && !dual && !pins.we_a_n && !pins.we_b_n) put(addr_q);
        if (sel_on && dual && !pins.we_a_n) put({1'b0, addr_q[11:0]});
        if (sel_on && dual && !pins.we_b_n) put({1'b1, addr_q[11:0]});
        if (rd_on && !pins.low_sel_n) last_q[7:0] = mem[rd_idx][7:0];
        if (rd_on && !pins.high_sel_n) last_q[15:8] = mem[rd_idx][15:8];
        drv[7:0] = (rd_on && !pins.low_sel_n) ? last_q[7:0] : ~last_q[7:0];
        drv[15:8] = (rd_on && !pins.high_sel_n) ? last_q[15:8] : ~last_q[15:8];
    end
endmodule

// ### testbench/latched_dual_bank_sram_tb_top.sv
// Self-checking bench for the latched dual bank memory controller.
`timescale 1ns/100ps

module latched_dual_bank_sram_tb_top
    import lds_pkg::*;
;
    logic clk, rst, dual, slow, req_valid, req_ready, rsp_valid, data_io_oe;
    lds_req_t req;
    lds_pins_t pins;
    logic [DATA_W-1:0] rsp_data, data_io_o, data_io_i, mem_out;
    logic [DATA_W-1:0] ref_mem [0:8191];
    logic [31:0] lfsr_q;
    int bad_count, total_checks;

    lds_host dut_u (.clk(clk), .rst(rst), .cfg_dual_mode(dual), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .latched_address(pins.address), .address_latch_strobe(pins.latch_strobe),
        .chip_enable_n(pins.chip_enable_n), .low_byte_select_n(pins.low_sel_n),
        .high_byte_select_n(pins.high_sel_n), .bank_a_output_enable_n(pins.oe_a_n),
        .bank_b_output_enable_n(pins.oe_b_n), .bank_a_write_enable_n(pins.we_a_n),
        .bank_b_write_enable_n(pins.we_b_n), .data_io_i(data_io_i), .data_io_o(data_io_o),
        .data_io_oe(data_io_oe));
    lds_mem_model mem_u (.dual(dual), .slow(slow), .pins(pins), .bus_in(data_io_i),
        .bus_out(mem_out));

    // Pin level seen by both parties.
    assign pins.data_oe = data_io_oe;
    assign data_io_i = data_io_oe ? data_io_o : mem_out;

    always #12.5 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One request; reads compare the enabled bytes with the shadow copy.
    task automatic do_req(input logic wr, input logic [1:0] bm, input logic [12:0] ad,
        input logic [1:0] be, input logic [15:0] wd);
        int n;
        logic [15:0] m;
        logic [12:0] ix;
        m = {be[1] ? 8'hff : 8'h00, (be[0] || be == 2'b00) ? 8'hff : 8'h00};
        ix = dual ? {bm == 2'b10, ad[11:0]} : ad;
        req = '{write: wr, bank_mask: bm, addr: ad, byte_en: be, wdata: wd};
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        if (wr && !dual) ref_mem[ad] = (ref_mem[ad] & ~m) | (wd & m);
        for (int b = 0; b < 2; b++) begin
            ix = {b[0], ad[11:0]};
            if (wr && dual && bm[b]) ref_mem[ix] = (ref_mem[ix] & ~m) | (wd & m);
        end
        ix = dual ? {bm == 2'b10, ad[11:0]} : ad;
        while ((wr ? req_ready !== 1'b1 : rsp_valid !== 1'b1) && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50 + 50 * !wr) begin
            bad_count++;
            report_and_stop();
        end else if (!wr) check(rsp_data & m, ref_mem[ix] & m);
    endtask

    // Wire watch on enables and the address top bit.
    always @(negedge clk) begin
        if (!rst && !dual) check({14'h0000, pins.oe_a_n, pins.we_a_n},
            {14'h0000, pins.oe_b_n, pins.we_b_n});
        if (!rst && dual && pins.latch_strobe) check({15'h0000, pins.address[12]}, 16'h0000);
        if (!(pins.oe_a_n && pins.oe_b_n)) check({14'h0000, pins.we_a_n, pins.we_b_n},
            16'h0003);
    end

    // Main sequence: corner cases then random traffic in each mode.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        dual = 1'b0;
        slow = 1'b0;
        req_valid = 1'b0;
        req = '0;
        lfsr_q = 32'h0000_1614;
        bad_count = 0;
        total_checks = 0;
        for (int i = 0; i < 8192; i++) ref_mem[i] = '0;
        for (int md = 0; md < 2; md++) begin
            rst = 1'b1;
            dual = md[0];
            repeat (4) @(negedge clk);
            rst = 1'b0;
            do_req(1'b1, 2'b01, 13'h1fff, 2'b11, 16'ha5c3);
            do_req(1'b0, 2'b01, 13'h0fff, 2'b11, 16'h0000);
            do_req(1'b1, 2'b11, 13'h0000, 2'b10, 16'h1234);
            do_req(1'b1, 2'b10, 13'h0000, 2'b01, 16'h5678);
            do_req(1'b1, 2'b00, 13'h0000, 2'b00, 16'h9abc);
            for (int k = 0; k < 3; k++) do_req(1'b0, k[1:0], 13'h0000, 2'b11, 16'h0000);
            for (int k = 0; k < 60; k++) begin
                lfsr_q = lfsr_next(lfsr_q);
                slow = lfsr_q[31];
                do_req(lfsr_q[30], lfsr_q[29:28], {lfsr_q[12], 8'h00, lfsr_q[3:0]},
                    lfsr_q[27:26], lfsr_q[25:10]);
            end
        end
        report_and_stop();
    end
endmodule
